// [logic/vim_mapper.sv]
// vectored interrupt mapper: source merge, fixed priority, halt wake-up, two-byte vector fetch
`timescale 1ns/1ps
`include "vim_defs.svh"
module vim_mapper
  import vim_pkg::*;
#(
  parameter int NSRC = `VIM_NUM_SRC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic top_level_ext_irq,
  input wire logic clock_timebase_source,
  input wire logic ext_line_zero,
  input wire logic auto_wakeup_from_halt,
  input wire logic ext_line_one,
  input wire logic aux_voltage_detector,
  input wire logic ext_line_two,
  input wire logic ext_line_three,
  input wire logic can_rx_irq,
  input wire logic can_tx_irq,
  input wire logic can_err_irq,
  input wire logic can_status_irq,
  input wire logic can_bus_wakeup,
  input wire logic can_sc_clear,
  input wire logic spi_irq,
  input wire logic eight_bit_timer,
  input wire logic sixteen_bit_timer,
  input wire logic lin_serial_two,
  input wire logic lin_serial_one,
  input wire logic serial_receive_pin,
  input wire logic pwm_autoreload_timer,
  input wire logic halt_mode,
  input wire logic active_halt_mode,
  output logic irq_pending,
  output logic [`VIM_NUM_W-1:0] irq_num,
  input wire logic irq_ack,
  output logic fetch_rd,
  output logic [`VIM_ADDR_W-1:0] fetch_addr,
  input wire logic [`VIM_DATA_W-1:0] fetch_data,
  output logic [`VIM_ADDR_W-1:0] handler_addr,
  output logic handler_valid,
  output logic [`VIM_NUM_W-1:0] served_num,
  output logic busy,
  output logic halt_exit
);

  function automatic logic [`VIM_ADDR_W-1:0] vim_vec_addr(input logic [`VIM_NUM_W-1:0] n);
    logic [`VIM_ADDR_W-1:0] ofs;
    ofs = `VIM_ADDR_W'(n) * `VIM_VEC_STEP;
    return `VIM_VEC_TOP - ofs;
  endfunction

  vim_req_if #(.NSRC(NSRC)) rq ();

  vim_prio #(.NSRC(NSRC)) u_prio (
    .rq(rq.enc)
  );

  vim_state_t state_r;
  vim_state_t state_nxt;
  logic sc_pend_r;
  logic sc_pend_nxt;
  logic fetch_rd_r;
  logic [`VIM_ADDR_W-1:0] fetch_addr_r;
  logic [`VIM_ADDR_W-1:0] fetch_addr_nxt;
  logic [`VIM_DATA_W-1:0] hi_byte_r;
  logic [`VIM_ADDR_W-1:0] handler_addr_r;
  logic handler_valid_r;
  logic [`VIM_NUM_W-1:0] served_num_r;
  logic halt_exit_r;

  // state decodes shared by the handshake, the read strobe and the capture registers
  wire st_idle = state_r == VIM_IDLE;
  wire st_lo = state_r == VIM_LO;
  wire st_done = state_r == VIM_DONE;
  wire rd_nxt = (state_nxt == VIM_HI) | (state_nxt == VIM_LO);

  wire in_halt = halt_mode | active_halt_mode;
  // an ack while busy or with nothing pending is dropped; the core must ask again
  wire take = irq_ack & rq.hit & st_idle;

  // shared sources merge their members into one request line
  wire req_src2 = ext_line_zero | auto_wakeup_from_halt;
  wire req_src3 = ext_line_one | aux_voltage_detector;
  // a bus wake-up in halt or active halt is reported as a status change on the shared CAN line
  wire req_src7 = can_tx_irq | can_err_irq | can_status_irq | sc_pend_r;

  // source numbers set priority: index 0 is served first, index 13 last
  wire [NSRC-1:0] req_vec = {
    pwm_autoreload_timer,
    lin_serial_one,
    lin_serial_two,
    sixteen_bit_timer,
    eight_bit_timer,
    spi_irq,
    req_src7,
    can_rx_irq,
    ext_line_three,
    ext_line_two,
    req_src3,
    req_src2,
    clock_timebase_source,
    top_level_ext_irq
  };

  assign rq.req = req_vec;

  // wake sources; peripherals on a stopped clock only get out through their pins
  wire wake_top = top_level_ext_irq;
  wire wake_src2 = ext_line_zero | auto_wakeup_from_halt;
  // the voltage detector shares source 3 but must not end halt
  wire wake_src3 = ext_line_one;
  wire wake_ext = ext_line_two | ext_line_three;
  // CAN data interrupts need the stopped clock; only a bus wake-up gets through
  wire wake_can = can_bus_wakeup;
  // the LIN receiver is stopped too; its receive pin interrupt is the way out
  wire wake_lin = serial_receive_pin;
  wire wake_per = spi_irq | pwm_autoreload_timer;
  // the eight- and sixteen-bit timers and the second serial line have no wake path on purpose
  wire wake_plain = wake_top | wake_src2 | wake_src3 | wake_ext
    | wake_can | wake_lin | wake_per;
  // the time-base clock only runs in active halt, so it cannot wake plain halt
  wire wake_tb = clock_timebase_source & active_halt_mode;
  wire wake_ev = in_halt & (wake_plain | wake_tb);

  assign irq_pending = rq.hit & st_idle;
  assign irq_num = rq.num;
  assign busy = ~st_idle;

  // set wins over clear so a wake-up in halt arriving with the clear is kept
  assign sc_pend_nxt = (in_halt & can_bus_wakeup) | (sc_pend_r & ~can_sc_clear);

  always_comb begin
    state_nxt = state_r;
    fetch_addr_nxt = fetch_addr_r;
    case (state_r)
      VIM_IDLE: begin
        if (take) begin
          state_nxt = VIM_HI;
          fetch_addr_nxt = vim_vec_addr(rq.num);
        end
      end
      VIM_HI: begin
        state_nxt = VIM_LO;
        fetch_addr_nxt = fetch_addr_r + `VIM_VEC_LO_OFS;
      end
      VIM_LO: begin
        state_nxt = VIM_DONE;
      end
      VIM_DONE: begin
        state_nxt = VIM_IDLE;
      end
      default: begin
        state_nxt = VIM_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_r <= VIM_IDLE;
      sc_pend_r <= 1'b0;
      fetch_addr_r <= '0;
      served_num_r <= '0;
      halt_exit_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sc_pend_r <= sc_pend_nxt;
      fetch_addr_r <= fetch_addr_nxt;
      halt_exit_r <= wake_ev;
      if (take) begin
        served_num_r <= rq.num;
      end
    end
  end

  // memory answers one cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      fetch_rd_r <= 1'b0;
      hi_byte_r <= '0;
      handler_addr_r <= '0;
      handler_valid_r <= 1'b0;
    end else begin
      fetch_rd_r <= rd_nxt;
      handler_valid_r <= st_done;
      // the high byte waits here so handler_addr changes in one step
      if (st_lo) begin
        hi_byte_r <= fetch_data;
      end
      if (st_done) begin
        handler_addr_r <= {hi_byte_r, fetch_data};
      end
    end
  end

  assign fetch_rd = fetch_rd_r;
  assign fetch_addr = fetch_addr_r;
  assign handler_addr = handler_addr_r;
  assign handler_valid = handler_valid_r;
  assign served_num = served_num_r;
  assign halt_exit = halt_exit_r;
endmodule

// [logic/vim_defs.svh]
// constants for the vectored interrupt mapper: source numbers, vector layout, widths
`ifndef VIM_DEFS_SVH
`define VIM_DEFS_SVH

`define VIM_NUM_SRC 14
`define VIM_NUM_W 4
`define VIM_ADDR_W 16
`define VIM_DATA_W 8

`define VIM_SRC_TOP_EXT 4'h0
`define VIM_SRC_TIMEBASE 4'h1
`define VIM_SRC_EXT0_AWU 4'h2
`define VIM_SRC_EXT1_AUXV 4'h3
`define VIM_SRC_EXT2 4'h4
`define VIM_SRC_EXT3 4'h5
`define VIM_SRC_CAN_RX 4'h6
`define VIM_SRC_CAN_TES 4'h7
`define VIM_SRC_SPI 4'h8
`define VIM_SRC_EIGHT_BIT_TIMER 4'h9
`define VIM_SRC_SIXTEEN_BIT_TIMER 4'ha
`define VIM_SRC_LIN2 4'hb
`define VIM_SRC_LIN1 4'hc
`define VIM_SRC_PWM 4'hd

// vector of source 0 lies at the top; each following source sits two bytes lower
`define VIM_VEC_TOP 16'hfffa
`define VIM_VEC_STEP 16'h0002
`define VIM_VEC_LO_OFS 16'h0001

`define VIM_FETCH_IDLE 2'h0
`define VIM_FETCH_HI 2'h1
`define VIM_FETCH_LO 2'h3
`define VIM_FETCH_DONE 2'h2

`endif

// [logic/vim_pkg.sv]
// types of the vectored interrupt mapper
package vim_pkg;
  `include "vim_defs.svh"

  typedef enum logic [1:0] {
    VIM_IDLE = `VIM_FETCH_IDLE,
    VIM_HI = `VIM_FETCH_HI,
    VIM_LO = `VIM_FETCH_LO,
    VIM_DONE = `VIM_FETCH_DONE
  } vim_state_t;

  typedef logic [`VIM_NUM_W-1:0] vim_num_t;
endpackage

// [logic/vim_req_if.sv]
// request vector and winning source between the mapper and its priority encoder
`timescale 1ns/1ps
interface vim_req_if #(
  parameter int NSRC = 14
);
  logic [NSRC-1:0] req;
  logic [3:0] num;
  logic hit;

  modport enc (
    input req,
    output num,
    output hit
  );

  modport top (
    output req,
    input num,
    input hit
  );
endinterface

// [logic/vim_prio.sv]
// fixed-priority encoder: lowest source number wins
`timescale 1ns/1ps
module vim_prio
  import vim_pkg::*;
#(
  parameter int NSRC = 14
) (
  vim_req_if.enc rq
);

  function automatic logic [3:0] vim_first(input logic [NSRC-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    // scan from the top so the lowest pending number is written last
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        n = 4'(i);
      end
    end
    return n;
  endfunction

  assign rq.num = vim_first(rq.req);
  assign rq.hit = |rq.req;
endmodule

// [tb/vim_mapper_props.sv]
// assertions on the mapper ports: priority, vector fetch timing and halt wake-up
`timescale 1ns/1ps
module vim_mapper_props (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic top_level_ext_irq,
  input wire logic eight_bit_timer,
  input wire logic pwm_autoreload_timer,
  input wire logic halt_mode,
  input wire logic active_halt_mode,
  input wire logic irq_pending,
  input wire logic [3:0] irq_num,
  input wire logic irq_ack,
  input wire logic fetch_rd,
  input wire logic [15:0] fetch_addr,
  input wire logic handler_valid,
  input wire logic [3:0] served_num,
  input wire logic busy,
  input wire logic halt_exit
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  wire taken = irq_ack && irq_pending;
  top_first_a: assert property (irq_pending && top_level_ext_irq |-> irq_num == 4'h0)
    else $error("top source not served first");
  pwm_last_a: assert property (irq_pending && irq_num == 4'hd |-> pwm_autoreload_timer && !eight_bit_timer)
    else $error("lowest source chosen over a higher one");
  fetch_addr_a: assert property (taken |=> fetch_rd && fetch_addr == 16'hfffa - {11'h000, $past(irq_num), 1'h0})
    else $error("vector address wrong");
  addr_pair_a: assert property ($rose(fetch_rd) |=> fetch_addr == $past(fetch_addr) + 16'h0001)
    else $error("second vector byte address wrong");
  rd_two_a: assert property ($rose(fetch_rd) |=> fetch_rd ##1 !fetch_rd)
    else $error("read strobe not two cycles");
  valid_lat_a: assert property (taken |-> ##4 handler_valid)
    else $error("handler not ready four cycles after ack");
  busy_run_a: assert property (taken |=> busy [*3] ##1 !busy)
    else $error("busy window wrong");
  served_num_a: assert property (taken |=> served_num == $past(irq_num))
    else $error("served source differs from winner");
  top_wake_a: assert property ((halt_mode || active_halt_mode) && top_level_ext_irq |=> halt_exit)
    else $error("top source did not end halt");
  no_halt_a: assert property (!halt_mode && !active_halt_mode |=> !halt_exit)
    else $error("halt exit outside halt");
  cover property (taken ##4 handler_valid);
  cover property (halt_exit);
  cover property (taken && irq_num == 4'hd);
endmodule

// [tb/vim_pmem.sv]
// program memory model holding the vector table, one cycle read latency
`timescale 1ns/1ps
module vim_pmem (
  input wire logic sys_clk,
  input wire logic fetch_rd,
  input wire logic [15:0] fetch_addr,
  output logic [7:0] fetch_data
);
  // each byte derives from its address so a swapped or misaddressed pair shows;
  // idle bus toggles rather than holding the last byte
  logic [7:0] data_r = 8'h00;
  always @(posedge sys_clk) data_r <= fetch_rd ? fetch_addr[7:0] ^ 8'h3c : ~data_r;
  assign fetch_data = data_r;
endmodule

// [tb/vim_mapper_tb_top.sv]
// bench for the vectored interrupt mapper: source mapping, wake-up and vector fetch
`timescale 1ns/1ps
module vim_mapper_tb_top;
  import vim_pkg::*;
  typedef struct packed {
    logic [13:0] s;
    logic [8:0] x;
    logic p;
    logic [3:0] n;
    logic w;
  } vim_row_t;
  logic sys_clk, nrst, irq_ack, irq_pending, fetch_rd, handler_valid, busy, halt_exit;
  logic [13:0] s;
  logic [8:0] x;
  logic [3:0] irq_num, served_num;
  logic [15:0] fetch_addr, handler_addr;
  logic [7:0] fetch_data;
  int failures, n_tests, cyc;
  // x: awu, auxv, can err, can status, bus wake, sc clear, rx pin, halt, active halt
  vim_row_t rows[19] = '{
    '{14'h0001, 9'h080, 1'h1, 4'h0, 1'h1},
    '{14'h2001, 9'h000, 1'h1, 4'h0, 1'h0},
    '{14'h0002, 9'h100, 1'h1, 4'h1, 1'h1},
    '{14'h0002, 9'h080, 1'h1, 4'h1, 1'h0},
    '{14'h0000, 9'h081, 1'h1, 4'h2, 1'h1},
    '{14'h0000, 9'h082, 1'h1, 4'h3, 1'h0},
    '{14'h0008, 9'h080, 1'h1, 4'h3, 1'h1},
    '{14'h0040, 9'h080, 1'h1, 4'h6, 1'h0},
    '{14'h0000, 9'h084, 1'h1, 4'h7, 1'h0},
    '{14'h0200, 9'h080, 1'h1, 4'h9, 1'h0},
    '{14'h0400, 9'h080, 1'h1, 4'ha, 1'h0},
    '{14'h1000, 9'h080, 1'h1, 4'hc, 1'h0},
    '{14'h1000, 9'h0c0, 1'h1, 4'hc, 1'h1},
    '{14'h2600, 9'h080, 1'h1, 4'h9, 1'h1},
    '{14'h0900, 9'h100, 1'h1, 4'h8, 1'h1},
    '{14'h0000, 9'h090, 1'h1, 4'h7, 1'h1},
    '{14'h0000, 9'h000, 1'h1, 4'h7, 1'h0},
    '{14'h0000, 9'h0b0, 1'h1, 4'h7, 1'h1},
    '{14'h0000, 9'h020, 1'h0, 4'h0, 1'h0}};
  vim_mapper dut (
    .top_level_ext_irq(s[0]), .clock_timebase_source(s[1]), .ext_line_zero(s[2]),
    .ext_line_one(s[3]), .ext_line_two(s[4]), .ext_line_three(s[5]), .can_rx_irq(s[6]),
    .can_tx_irq(s[7]), .spi_irq(s[8]), .eight_bit_timer(s[9]), .sixteen_bit_timer(s[10]),
    .lin_serial_two(s[11]), .lin_serial_one(s[12]), .pwm_autoreload_timer(s[13]),
    .auto_wakeup_from_halt(x[0]), .aux_voltage_detector(x[1]), .can_err_irq(x[2]),
    .can_status_irq(x[3]), .can_bus_wakeup(x[4]), .can_sc_clear(x[5]),
    .serial_receive_pin(x[6]), .halt_mode(x[7]), .active_halt_mode(x[8]),
    .sys_clk(sys_clk), .nrst(nrst), .irq_pending(irq_pending), .irq_num(irq_num), .irq_ack(irq_ack),
    .fetch_rd(fetch_rd), .fetch_addr(fetch_addr), .fetch_data(fetch_data), .handler_addr(handler_addr),
    .handler_valid(handler_valid), .served_num(served_num), .busy(busy), .halt_exit(halt_exit)
  );
  vim_pmem mem (.sys_clk(sys_clk), .fetch_rd(fetch_rd), .fetch_addr(fetch_addr), .fetch_data(fetch_data));
  always #4 sys_clk = ~sys_clk;
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wrap_up;
    if (failures == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ack for one edge, then look at the result in the cycle the handler is reported
  task automatic fetch(input logic [3:0] n);
    logic [15:0] v;
    v = 16'hfffa - {11'h000, n, 1'h0};
    @(posedge sys_clk);
    irq_ack <= 1'h1;
    @(posedge sys_clk);
    irq_ack <= 1'h0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(handler_valid, 1'h1);
    chk(served_num, n);
    chk(handler_addr, {v[7:0] ^ 8'h3c, v[7:0] ^ 8'h3d});
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    sys_clk = 1'h0;
    nrst = 1'h0;
    irq_ack = 1'h0;
    s = 14'h0000;
    x = 9'h000;
    repeat (5) @(posedge sys_clk);
    #1;
    chk(fetch_rd, 1'h0);
    chk(handler_valid, 1'h0);
    @(posedge sys_clk);
    nrst <= 1'h1;
    foreach (rows[i]) begin
      @(posedge sys_clk);
      s <= rows[i].s;
      x <= rows[i].x;
      repeat (2) @(posedge sys_clk);
      #1;
      chk(irq_pending, rows[i].p);
      if (rows[i].p) chk(irq_num, rows[i].n);
      chk(halt_exit, rows[i].w);
    end
    for (int n = 0; n < 14; n++) begin
      @(posedge sys_clk);
      s <= 14'h0001 << n;
      x <= 9'h000;
      fetch(n[3:0]);
    end
    @(posedge sys_clk);
    s <= 14'h2200;
    fetch(4'h9);
    // reset in the middle of a fetch drops it and clears every registered output
    @(posedge sys_clk);
    s <= 14'h0040;
    irq_ack <= 1'h1;
    @(posedge sys_clk);
    irq_ack <= 1'h0;
    @(posedge sys_clk);
    nrst <= 1'h0;
    @(posedge sys_clk);
    nrst <= 1'h1;
    #1;
    chk(busy, 1'h0);
    chk(fetch_rd, 1'h0);
    chk(served_num, 4'h0);
    chk(handler_addr, 16'h0000);
    chk(irq_pending, 1'h1);
    fetch(4'h6);
    wrap_up();
  end
endmodule
bind vim_mapper vim_mapper_props props (
  .sys_clk(sys_clk), .nrst(nrst), .top_level_ext_irq(top_level_ext_irq), .eight_bit_timer(eight_bit_timer),
  .pwm_autoreload_timer(pwm_autoreload_timer), .halt_mode(halt_mode), .active_halt_mode(active_halt_mode),
  .irq_pending(irq_pending), .irq_num(irq_num), .irq_ack(irq_ack), .fetch_rd(fetch_rd), .fetch_addr(fetch_addr),
  .handler_valid(handler_valid), .served_num(served_num), .busy(busy), .halt_exit(halt_exit)
);
